// ==== fws_pkg.sv ====
// Constants and types for the flash write-status polling controller
// Contract
// - Host combines both toggle bits to learn sector and suspend state.
// - Host starts status checks with two consecutive full-byte reads.
// - Toggle bit steady across two reads means done; next read valid.
// - Toggling with timeout bit high: host rechecks toggle once more.
// - Still toggling after recheck: host reports failure, issues reset.
// - Host resuming after pause restarts from the first double read.
// - After any timeout failure host sends the reset command.
// - Host may skip window bit only if commands under 50 us apart.
// - Host confirms acceptance by polling or toggle before reading window bit.
// - Host reads window bit before and after each added sector command.
// - Host reads polling and erase toggle bits at a valid address.
package fws_pkg;
	localparam int unsigned ADDR_W_DEF    = 20;
	localparam int unsigned DATA_W_DEF    = 8;
	localparam int unsigned CLK_MHZ       = 20;
	localparam int unsigned SPACING_US    = 50;
	localparam int unsigned SPACING_CYC   = SPACING_US * CLK_MHZ;
	localparam int unsigned RD_CYC_DEF    = 4;
	localparam int unsigned BIT_POLL      = 7;
	localparam int unsigned BIT_ALG_TOG   = 6;
	localparam int unsigned BIT_TMO       = 5;
	localparam int unsigned BIT_WINDOW    = 3;
	localparam int unsigned BIT_ERS_TOG   = 2;
	localparam logic [7:0]  RESET_CMD     = 8'hf0;

	typedef enum logic [1:0] {
		FWS_OP_STATUS,
		FWS_OP_ADD_SECTOR,
		FWS_OP_RESET
	} fws_op_type;

	typedef enum logic [2:0] {
		FWS_RES_NONE,
		FWS_RES_DONE,
		FWS_RES_FAIL,
		FWS_RES_ADD_OK,
		FWS_RES_ADD_REJ,
		FWS_RES_RESET_DONE
	} fws_res_type;
endpackage

// ==== fws_bus_cycle.sv ====
// One timed read or write cycle on the flash parallel bus
`timescale 1ns/1ns
module fws_bus_cycle #(
	parameter int unsigned ADDR_W = 20,
	parameter int unsigned DATA_W = 8,
	parameter int unsigned CYC    = 4
) (
	input  wire logic              clk_sys,
	input  wire logic              resetn,
	input  wire logic              ce,
	input  wire logic              start,
	input  wire logic              is_write,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] wdata,
	input  wire logic [DATA_W-1:0] dq_in,
	output logic                   busy,
	output logic                   done,
	output logic [DATA_W-1:0]      rdata,
	output logic [ADDR_W-1:0]      fl_addr,
	output logic [DATA_W-1:0]      dq_out,
	output logic                   dq_oe,
	output logic                   fl_ce_n,
	output logic                   fl_oe_n,
	output logic                   fl_we_n
);
	localparam logic [7:0] LAST = 8'(CYC - 1);
	logic [7:0]        cnt_ff, nxt_cnt;
	logic              busy_ff, nxt_busy, done_ff, nxt_done, wr_ff, nxt_wr;
	logic [DATA_W-1:0] rd_ff, nxt_rd;
	logic [ADDR_W-1:0] a_ff, nxt_a;
	logic [DATA_W-1:0] w_ff, nxt_w;

	always_comb begin
		nxt_cnt  = cnt_ff;
		nxt_busy = busy_ff;
		nxt_done = 1'b0;
		nxt_wr   = wr_ff;
		nxt_rd   = rd_ff;
		nxt_a    = a_ff;
		nxt_w    = w_ff;
		if (!busy_ff && start) begin
			nxt_busy = 1'b1;
			nxt_cnt  = 8'h00;
			nxt_wr   = is_write;
			nxt_a    = addr;
			nxt_w    = wdata;
		end else if (busy_ff) begin
			if (cnt_ff == LAST) begin
				nxt_busy = 1'b0;
				nxt_done = 1'b1;
				// Sample at the end of the strobe, data settled
				if (!wr_ff)
					nxt_rd = dq_in;
			end else begin
				nxt_cnt = cnt_ff + 8'h01;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			cnt_ff  <= 8'h00;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
			wr_ff   <= 1'b0;
			rd_ff   <= '0;
			a_ff    <= '0;
			w_ff    <= '0;
		end else if (ce) begin
			cnt_ff  <= nxt_cnt;
			busy_ff <= nxt_busy;
			done_ff <= nxt_done;
			wr_ff   <= nxt_wr;
			rd_ff   <= nxt_rd;
			a_ff    <= nxt_a;
			w_ff    <= nxt_w;
		end
	end

	// Strobe drops on last count and fl_we_n is high then, so write data latches on its rise
	logic strobe;
	assign strobe = busy_ff && (cnt_ff != LAST);
	logic ce_n_ff, oe_n_ff, we_n_ff, oe_ff;
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			ce_n_ff <= 1'b1;
			oe_n_ff <= 1'b1;
			we_n_ff <= 1'b1;
			oe_ff   <= 1'b0;
		end else if (ce) begin
			ce_n_ff <= !nxt_busy;
			oe_n_ff <= !(nxt_busy && !nxt_wr);
			we_n_ff <= !(nxt_busy && nxt_wr && (nxt_cnt != LAST));
			oe_ff   <= nxt_busy && nxt_wr;
		end
	end
	assign busy    = busy_ff;
	assign done    = done_ff;
	assign rdata   = rd_ff;
	assign fl_addr = a_ff;
	assign dq_out  = w_ff;
	assign dq_oe   = oe_ff;
	assign fl_ce_n = ce_n_ff;
	assign fl_oe_n = oe_n_ff;
	assign fl_we_n = we_n_ff;
endmodule

// ==== fws_ctrl.sv ====
// Host-side status poller for flash program and erase algorithms
`timescale 1ns/1ns
module fws_ctrl
	import fws_pkg::*;
#(
	parameter int unsigned ADDR_W  = fws_pkg::ADDR_W_DEF,
	parameter int unsigned DATA_W  = fws_pkg::DATA_W_DEF,
	parameter int unsigned RD_CYC  = fws_pkg::RD_CYC_DEF,
	parameter int unsigned GAP_CYC = fws_pkg::SPACING_CYC
) (
	input  wire logic                  clk_sys,
	input  wire logic                  resetn,
	input  wire logic                  clk_en,
	input  wire logic                  req,
	input  wire fws_pkg::fws_op_type   req_op,
	input  wire logic [ADDR_W-1:0]     req_addr,
	input  wire logic [ADDR_W-1:0]     req_cmd_addr,
	input  wire logic [DATA_W-1:0]     req_cmd_data,
	input  wire logic                  req_is_erase,
	input  wire logic                  abort,
	output logic                       ack_ff,
	output fws_pkg::fws_res_type       result_ff,
	output logic                       busy_ff,
	output logic                       suspended_ff,
	output logic                       sector_erasing_ff,
	output logic                       window_closed_ff,
	output logic                       fl_busy_ff,
	output logic [DATA_W-1:0]          data_ff,
	input  wire logic [DATA_W-1:0]     fl_dq_in,
	input  wire logic                  fl_ready_busy_n,
	output logic [ADDR_W-1:0]          fl_addr,
	output logic [DATA_W-1:0]          fl_dq_out,
	output logic                       fl_dq_oe,
	output logic                       fl_ce_n,
	output logic                       fl_oe_n,
	output logic                       fl_we_n
);
	import fws_pkg::*;

	typedef enum {
		ST_IDLE, ST_RD1, ST_RD2, ST_RECHK, ST_DATA,
		ST_WIN_PRE, ST_ADD_WR, ST_ACCEPT, ST_WIN_POST, ST_RST
	} fws_state_type;

	fws_state_type     st_ff, nxt_st;
	fws_op_type        op_ff, nxt_op;
	logic [ADDR_W-1:0] addr_ff, nxt_addr;
	logic [DATA_W-1:0] first_ff, nxt_first;
	logic              erase_ff, nxt_erase;
	logic              ack_nxt;
	fws_res_type       res_nxt;
	logic              susp_nxt, secer_nxt, winc_nxt;
	logic [DATA_W-1:0] data_nxt;
	logic              cyc_start, cyc_wr, cyc_busy, cyc_done;
	logic [ADDR_W-1:0] cyc_addr;
	logic [DATA_W-1:0] cyc_wdata, cyc_rdata;
	logic [31:0]       gap_ff, nxt_gap;

	function automatic logic toggled(input logic [DATA_W-1:0] a,
	                                 input logic [DATA_W-1:0] b,
	                                 input logic ers);
		// Erase checks look at both toggle bits; program at the algorithm one
		toggled = (a[BIT_ALG_TOG] != b[BIT_ALG_TOG]) ||
		          (ers && (a[BIT_ERS_TOG] != b[BIT_ERS_TOG]));
	endfunction

	fws_bus_cycle #(
		.ADDR_W (ADDR_W),
		.DATA_W (DATA_W),
		.CYC    (RD_CYC)
	) u_cyc (
		.clk_sys  (clk_sys),
		.resetn   (resetn),
		.ce       (clk_en),
		.start    (cyc_start),
		.is_write (cyc_wr),
		.addr     (cyc_addr),
		.wdata    (cyc_wdata),
		.dq_in    (fl_dq_in),
		.busy     (cyc_busy),
		.done     (cyc_done),
		.rdata    (cyc_rdata),
		.fl_addr  (fl_addr),
		.dq_out   (fl_dq_out),
		.dq_oe    (fl_dq_oe),
		.fl_ce_n  (fl_ce_n),
		.fl_oe_n  (fl_oe_n),
		.fl_we_n  (fl_we_n)
	);

	always_comb begin
		nxt_st    = st_ff;
		nxt_op    = op_ff;
		nxt_addr  = addr_ff;
		nxt_first = first_ff;
		nxt_erase = erase_ff;
		nxt_gap   = gap_ff;
		ack_nxt   = 1'b0;
		res_nxt   = result_ff;
		susp_nxt  = suspended_ff;
		secer_nxt = sector_erasing_ff;
		winc_nxt  = window_closed_ff;
		data_nxt  = data_ff;
		cyc_start = 1'b0;
		cyc_wr    = 1'b0;
		cyc_addr  = addr_ff;
		cyc_wdata = '0;
		if (gap_ff != 32'h0)
			nxt_gap = gap_ff - 32'h1;
		case (st_ff)
		ST_IDLE: begin
			if (req) begin
				nxt_op    = req_op;
				nxt_addr  = req_addr;   // Must be a valid status address
				nxt_erase = req_is_erase;
				case (req_op)
				FWS_OP_STATUS:     nxt_st = ST_RD1;  // Fresh double read
				FWS_OP_ADD_SECTOR: nxt_st = ST_WIN_PRE;
				FWS_OP_RESET:      nxt_st = ST_RST;
				default:           nxt_st = ST_IDLE;
				endcase
			end
		end
		ST_RD1, ST_RD2, ST_RECHK, ST_DATA, ST_WIN_PRE, ST_WIN_POST: begin
			cyc_start = !cyc_busy && !cyc_done;
			if (cyc_done) begin
				case (st_ff)
				ST_RD1: begin
					nxt_first = cyc_rdata;
					nxt_st    = ST_RD2;
				end
				ST_RD2, ST_RECHK: begin
					nxt_first = cyc_rdata;
					if (!toggled(first_ff, cyc_rdata, erase_ff)) begin
						nxt_st = ST_DATA;  // Steady: array data next read
					end else if (st_ff == ST_RECHK) begin
						nxt_st  = ST_RST;  // Failed: reset to array
						res_nxt = FWS_RES_FAIL;
					end else if (cyc_rdata[BIT_TMO]) begin
						nxt_st = ST_RECHK;  // Toggle may stop as flag rises
					end else if (abort) begin
						nxt_st  = ST_IDLE;  // Paused; next request restarts
						ack_nxt = 1'b1;
						res_nxt = FWS_RES_NONE;
					end
					secer_nxt = cyc_rdata[BIT_ERS_TOG] != first_ff[BIT_ERS_TOG];
					susp_nxt  = secer_nxt && (cyc_rdata[BIT_ALG_TOG] ==
					            first_ff[BIT_ALG_TOG]);
				end
				ST_DATA: begin
					data_nxt = cyc_rdata;
					nxt_st   = ST_IDLE;
					ack_nxt  = 1'b1;
					res_nxt  = FWS_RES_DONE;
				end
				ST_WIN_PRE: begin
					winc_nxt = cyc_rdata[BIT_WINDOW];
					if (cyc_rdata[BIT_WINDOW]) begin
						// Erase already running; command would be ignored
						nxt_st  = ST_IDLE;
						ack_nxt = 1'b1;
						res_nxt = FWS_RES_ADD_REJ;
					end else begin
						nxt_st = ST_ADD_WR;
					end
				end
				default: begin
					winc_nxt = cyc_rdata[BIT_WINDOW];
					nxt_st   = ST_IDLE;
					ack_nxt  = 1'b1;
					// High after the add: it may have been dropped
					res_nxt  = cyc_rdata[BIT_WINDOW] ? FWS_RES_ADD_REJ
					                                 : FWS_RES_ADD_OK;
				end
				endcase
			end
		end
		ST_ADD_WR: begin
			cyc_start = !cyc_busy && !cyc_done;
			cyc_wr    = 1'b1;
			cyc_addr  = req_cmd_addr;
			cyc_wdata = req_cmd_data;
			if (cyc_done) begin
				nxt_gap = GAP_CYC;  // Window restarts per added command
				nxt_st  = ST_ACCEPT;
			end
		end
		ST_ACCEPT: begin
			// Confirm acceptance via polling or toggle bit before the window bit
			cyc_start = !cyc_busy && !cyc_done;
			if (cyc_done) begin
				if (cyc_rdata[BIT_POLL] == 1'b0 || cyc_rdata[BIT_ALG_TOG] !=
				    first_ff[BIT_ALG_TOG])
					nxt_st = ST_WIN_POST;
				nxt_first = cyc_rdata;
			end
		end
		ST_RST: begin
			cyc_start = !cyc_busy && !cyc_done;
			cyc_wr    = 1'b1;
			cyc_wdata = DATA_W'(RESET_CMD);
			if (cyc_done) begin
				nxt_st  = ST_IDLE;
				ack_nxt = 1'b1;
				if (op_ff == FWS_OP_RESET)
					res_nxt = FWS_RES_RESET_DONE;
			end
		end
		default: nxt_st = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			st_ff             <= ST_IDLE;
			op_ff             <= FWS_OP_STATUS;
			addr_ff           <= '0;
			first_ff          <= '0;
			erase_ff          <= 1'b0;
			gap_ff            <= 32'h0;
			ack_ff            <= 1'b0;
			result_ff         <= FWS_RES_NONE;
			busy_ff           <= 1'b0;
			suspended_ff      <= 1'b0;
			sector_erasing_ff <= 1'b0;
			window_closed_ff  <= 1'b0;
			fl_busy_ff        <= 1'b0;
			data_ff           <= '0;
		end else if (clk_en) begin
			st_ff             <= nxt_st;
			op_ff             <= nxt_op;
			addr_ff           <= nxt_addr;
			first_ff          <= nxt_first;
			erase_ff          <= nxt_erase;
			gap_ff            <= nxt_gap;
			ack_ff            <= ack_nxt;
			result_ff         <= res_nxt;
			busy_ff           <= nxt_st != ST_IDLE;
			suspended_ff      <= susp_nxt;
			sector_erasing_ff <= secer_nxt;
			window_closed_ff  <= winc_nxt;
			fl_busy_ff        <= !fl_ready_busy_n;  // Low = busy
			data_ff           <= data_nxt;
		end
	end
endmodule

// ==== fws_ctrl_properties.sv ====
// Port assertions for the flash status poller
`timescale 1ns/1ns
module fws_ctrl_chk
	import fws_pkg::*;
#(
	parameter int unsigned ADDR_W = 20,
	parameter int unsigned DATA_W = 8
) (
	input wire logic                clk_sys,
	input wire logic                resetn,
	input wire logic                clk_en,
	input wire logic                req,
	input wire logic                ack_ff,
	input wire fws_pkg::fws_res_type result_ff,
	input wire logic                busy_ff,
	input wire logic                fl_busy_ff,
	input wire logic                fl_ready_busy_n,
	input wire logic [ADDR_W-1:0]   fl_addr,
	input wire logic [DATA_W-1:0]   fl_dq_out,
	input wire logic                fl_dq_oe,
	input wire logic                fl_ce_n,
	input wire logic                fl_oe_n,
	input wire logic                fl_we_n
);
	logic       oe_q_ff;
	logic       f0_ff;
	logic       nxt_f0;
	logic [1:0] rd_ff;
	logic [1:0] nxt_rd;
	default clocking cb @(posedge clk_sys); endclocking
	// Reads counted and reset writes flagged per operation, cleared by ack
	always_comb begin
		nxt_f0 = ack_ff ? 1'b0 : f0_ff;
		nxt_rd = ack_ff ? 2'h0 : rd_ff;
		if (!fl_we_n && fl_dq_out == RESET_CMD)
			nxt_f0 = 1'b1;
		if (oe_q_ff && !fl_oe_n && rd_ff != 2'h3)
			nxt_rd = rd_ff + 2'h1;
	end
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			oe_q_ff <= 1'b1;
			f0_ff <= 1'b0;
			rd_ff <= 2'h0;
		end else begin
			oe_q_ff <= fl_oe_n;
			f0_ff <= nxt_f0;
			rd_ff <= nxt_rd;
		end
	end
	sequence s_rd_hold;
		!fl_oe_n ##1 !fl_oe_n;
	endsequence
	sequence s_fail_ack;
		ack_ff && result_ff == FWS_RES_FAIL;
	endsequence
	a_reset_quiet: assert property (!resetn |=> fl_ce_n && fl_oe_n
		&& fl_we_n && !fl_dq_oe && !ack_ff && !busy_ff)
		else $error("bus active after reset");
	a_ack_pulse: assert property (disable iff (!resetn)
		ack_ff |=> !ack_ff) else $error("ack longer than a cycle");
	a_done_reads: assert property (disable iff (!resetn)
		ack_ff && result_ff == FWS_RES_DONE |-> rd_ff == 2'h3)
		else $error("done after fewer than three reads");
	a_fail_reset: assert property (disable iff (!resetn)
		s_fail_ack |-> f0_ff && rd_ff == 2'h3)
		else $error("failure without recheck and reset");
	a_addr_hold: assert property (disable iff (!resetn)
		s_rd_hold |-> $stable(fl_addr)) else $error("address moved in read");
	a_read_float: assert property (disable iff (!resetn)
		!fl_oe_n |-> !fl_dq_oe && fl_we_n) else $error("drive during read");
	a_write_drive: assert property (disable iff (!resetn)
		!fl_we_n |-> fl_dq_oe && !fl_ce_n) else $error("write undriven");
	a_busy_mirror: assert property (disable iff (!resetn)
		clk_en |=> fl_busy_ff == !$past(fl_ready_busy_n))
		else $error("busy flag does not follow pin");
	a_take_req: assert property (disable iff (!resetn)
		req && !busy_ff && clk_en |=> busy_ff)
		else $error("request not taken");
endmodule
bind fws_ctrl fws_ctrl_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_chk (
	.clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en), .req(req),
	.ack_ff(ack_ff), .result_ff(result_ff), .busy_ff(busy_ff),
	.fl_busy_ff(fl_busy_ff), .fl_ready_busy_n(fl_ready_busy_n),
	.fl_addr(fl_addr), .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe),
	.fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n));

// ==== fws_flash_model.sv ====
// Behavioural flash device giving status bytes during algorithms
`timescale 1ns/1ns
module fws_flash_model (
	input wire logic [19:0] fl_addr,
	input wire logic [7:0]  fl_dq_out,
	input wire logic        fl_dq_oe,
	input wire logic        fl_ce_n,
	input wire logic        fl_oe_n,
	input wire logic        fl_we_n,
	output logic [7:0]      fl_dq_in,
	output logic            fl_ready_busy_n
);
	int cnt = 0;
	int nwr = 0;
	logic tmo = 1'b0, win = 1'b0, susp = 1'b0, rst = 1'b0;
	logic tog = 1'b0, et = 1'b0;
	logic [7:0] arr = 8'ha5, q = 8'h00, wd = 8'h00;
	// Each status read outside timeout and suspend counts as one step of the algorithm
	always @(negedge fl_oe_n) begin
		// Address and chip enable move on the same edge; let them settle
		#1;
		if (!fl_ce_n && (cnt > 0 || susp)) begin
			tog = susp ? tog : ~tog;
			et = (fl_addr[19:12] == 8'h12) ? ~et : et;
			q = {susp, tog, tmo, 1'b0, win, et, 2'h0};
			cnt = (tmo || susp) ? cnt : cnt - 1;
		end else
			q = arr;
	end
	always @(fl_we_n or fl_dq_out)
		if (!fl_we_n)
			wd = fl_dq_out;
	always @(posedge fl_we_n) begin
		nwr++;
		if (wd == 8'hf0) begin
			cnt = 0;
			tmo = 1'b0;
			rst = 1'b1;
		end else if (!win && wd == 8'h30)
			cnt = 4;
	end
	// Released bus shows the inverse so stale data never passes
	assign fl_dq_in = fl_dq_oe ? fl_dq_out : (!fl_ce_n && !fl_oe_n) ? q : ~q;
	assign fl_ready_busy_n = !(cnt > 0 && !susp);
endmodule

// ==== tb_fws_ctrl.sv ====
// Testbench for the flash status poller against a device model
`timescale 1ns/1ns
module tb_fws_ctrl;
	import fws_pkg::*;
	logic clk_sys = 1'b0, resetn = 1'b0, req = 1'b0, ers = 1'b0, abt = 1'b0;
	fws_op_type op = FWS_OP_STATUS;
	logic [19:0] addr = 20'h00000, fl_addr;
	logic ack_ff, busy_ff, sus_ff, sec_ff, win_ff, flb_ff;
	logic oe, ce_n, oe_n, we_n, rb_n;
	fws_res_type result_ff;
	logic [7:0] data_ff, dq_o, dq_i;
	int err_count = 0;
	int compares = 0;
	always #25 clk_sys = ~clk_sys;
	fws_ctrl i_dut (.clk_sys(clk_sys), .resetn(resetn), .clk_en(1'b1),
		.req(req), .req_op(op), .req_addr(addr), .req_cmd_addr(addr),
		.req_cmd_data(8'h30), .req_is_erase(ers), .abort(abt),
		.ack_ff(ack_ff), .result_ff(result_ff), .busy_ff(busy_ff),
		.suspended_ff(sus_ff), .sector_erasing_ff(sec_ff),
		.window_closed_ff(win_ff), .fl_busy_ff(flb_ff), .data_ff(data_ff),
		.fl_dq_in(dq_i), .fl_ready_busy_n(rb_n), .fl_addr(fl_addr),
		.fl_dq_out(dq_o), .fl_dq_oe(oe), .fl_ce_n(ce_n), .fl_oe_n(oe_n),
		.fl_we_n(we_n));
	fws_flash_model i_flash (.fl_addr(fl_addr), .fl_dq_out(dq_o),
		.fl_dq_oe(oe), .fl_ce_n(ce_n), .fl_oe_n(oe_n), .fl_we_n(we_n),
		.fl_dq_in(dq_i), .fl_ready_busy_n(rb_n));
	task automatic chk_res(input string nm, input fws_res_type e, g);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("unexpected %s: expected %0d seen %0d", nm, e, g);
		end
	endtask
	task automatic chk_val(input string nm, input logic [7:0] e, g);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic summarize;
		if (err_count == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// One request, then a bounded wait for its ack
	task automatic run(input fws_op_type o, input logic [19:0] a,
		input logic e, input logic ab);
		int n;
		n = 0;
		@(posedge clk_sys);
		op <= o;
		addr <= a;
		ers <= e;
		abt <= ab;
		req <= 1'b1;
		@(posedge clk_sys);
		req <= 1'b0;
		while (ack_ff !== 1'b1 && n < 4000) begin
			@(negedge clk_sys);
			n++;
		end
		if (n >= 4000) begin
			err_count++;
			summarize();
		end
	endtask
	task automatic t_reset;
		i_flash.rst = 1'b0;
		run(FWS_OP_RESET, 20'h00000, 1'b0, 1'b0);
		chk_res("reset", FWS_RES_RESET_DONE, result_ff);
		chk_val("reset cmd", 8'h01, {7'h0, i_flash.rst});
	endtask
	// Erase check compares both toggle bits, program check only one
	task automatic t_done(input logic [19:0] a, input logic e);
		i_flash.cnt = 3;
		run(FWS_OP_STATUS, a, e, 1'b0);
		chk_res("done", FWS_RES_DONE, result_ff);
		chk_val("array", 8'ha5, data_ff);
	endtask
	task automatic t_fail;
		i_flash.cnt = 5;
		i_flash.tmo = 1'b1;
		i_flash.rst = 1'b0;
		run(FWS_OP_STATUS, 20'h12000, 1'b1, 1'b0);
		chk_res("fail", FWS_RES_FAIL, result_ff);
		chk_val("fail reset", 8'h01, {7'h0, i_flash.rst});
	endtask
	task automatic t_susp;
		i_flash.susp = 1'b1;
		run(FWS_OP_STATUS, 20'h12000, 1'b1, 1'b1);
		chk_res("abort", FWS_RES_NONE, result_ff);
		chk_val("suspend", 8'h03, {6'h0, sus_ff, sec_ff});
		chk_val("flash busy", 8'h00, {7'h0, flb_ff});
		i_flash.susp = 1'b0;
	endtask
	task automatic t_add;
		int n0;
		n0 = i_flash.nwr;
		i_flash.win = 1'b0;
		run(FWS_OP_ADD_SECTOR, 20'h13000, 1'b1, 1'b0);
		chk_res("add", FWS_RES_ADD_OK, result_ff);
		chk_val("add cmd", 8'h30, i_flash.wd);
		chk_val("add writes", 8'(n0 + 1), 8'(i_flash.nwr));
		chk_val("window", 8'h00, {7'h0, win_ff});
		chk_val("flash busy", 8'h01, {7'h0, flb_ff});
		n0 = i_flash.nwr;
		i_flash.win = 1'b1;
		i_flash.cnt = 8;
		run(FWS_OP_ADD_SECTOR, 20'h13000, 1'b1, 1'b0);
		chk_res("reject", FWS_RES_ADD_REJ, result_ff);
		chk_val("rej writes", 8'(n0), 8'(i_flash.nwr));
		chk_val("closed", 8'h01, {7'h0, win_ff});
		i_flash.win = 1'b0;
	endtask
	initial begin
		repeat (2) @(posedge clk_sys);
		resetn <= 1'b1;
		t_reset;
		t_done(20'h12040, 1'b1);
		t_done(20'h20000, 1'b0);
		t_fail;
		t_susp;
		t_add;
		t_reset;
		summarize();
	end
endmodule
